// ===== rtl/align_hold_timer.sv
// alignment hold timer counting 10 ms ticks
// assumes start is a one-cycle pulse on clk_sys, frozen with clk_en
`timescale 1ns/100ps
module align_hold_timer
  import startup_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = HOLD_TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  hold_if.timer     hold
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [16:0] presc;
    logic [10:0] remaining;
  } timer_s;

  timer_s q;
  timer_s next_q;

  // ****************************************
  // tick counting
  // ****************************************
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    if (hold.start) begin
      next_q.busy      = 1'b1;
      next_q.presc     = '0;
      next_q.remaining = hold.ticks;
    end else if (q.busy) begin
      if (q.presc == 17'(TICK_CYCLES - 1)) begin
        next_q.presc     = '0;
        next_q.remaining = q.remaining - 11'h001;
        if (q.remaining == 11'h001) begin
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
        end
      end else begin
        next_q.presc = q.presc + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign hold.busy = q.busy;
  assign hold.done = q.done;

endmodule

// ===== rtl/hold_if.sv
// start and completion handshake between start-up control and hold timer
// assumes both ends on clk_sys
`timescale 1ns/100ps
interface hold_if;
  logic        start;
  logic [10:0] ticks;
  logic        busy;
  logic        done;

  modport ctrl  (output start, output ticks, input busy, input done);
  modport timer (input start, input ticks, output busy, output done);
endinterface

// ===== rtl/motor_startup_config_decode.sv
// start-up configuration register and decode of its fields
// assumes register strobes, align_start and probe inputs come from clk_sys logic
`timescale 1ns/100ps

module motor_startup_config_decode
  import startup_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = HOLD_TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        align_start,
  input  wire logic [15:0] probe_angle,
  input  wire logic        probe_valid,
  input  wire logic [15:0] general_current_cap,
  input  wire logic [15:0] openloop_current_cap,
  output startup_method_e  startup_method_sel,
  output logic      [15:0] ramp_rate,
  output logic             ramp_unlimited,
  output logic      [15:0] prestart_current_cap,
  output logic             align_active,
  output logic             align_done,
  output logic      [15:0] position_probe_pulse_rate,
  output logic      [15:0] position_probe_threshold,
  output logic             position_probe_threshold_bad,
  output logic             position_probe_release,
  output logic      [15:0] position_probe_result,
  output logic             position_probe_result_valid,
  output logic      [15:0] openloop_cap,
  output logic             torque_current_rampdown_en,
  output logic             active_brake_en,
  output logic             reverse_param_set_sel
);

  typedef enum logic [1:0] {
    HOLD_IDLE   = 2'h0,
    HOLD_FIRST  = 2'h1,
    HOLD_SECOND = 2'h2
  } hold_state_e;

  typedef struct packed {
    logic [31:0]     cfg;
    logic [31:0]     rdata;
    hold_state_e     hstate;
    logic            align_done;
    logic [2:0]      probe_cnt;
    logic [17:0]     probe_sum;
    logic [15:0]     probe_result;
    logic            probe_valid;
    startup_method_e method;
    logic [15:0]     ramp;
    logic            ramp_inf;
    logic [15:0]     cap;
    logic [15:0]     pulse;
    logic [15:0]     thr;
    logic            thr_bad;
    logic            release_tri;
    logic [15:0]     ol_cap;
    logic            rampdown;
    logic            brake;
    logic            rev_sel;
  } state_s;

  state_s q;
  state_s next_q;

  hold_if hold ();

  logic        next_start;
  logic [10:0] next_ticks;

  align_hold_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_hold (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .hold    (hold.timer)
  );

  assign hold.start = next_start;
  assign hold.ticks = next_ticks;

  // ****************************************
  // field views of the stored word
  // ****************************************
  logic [1:0]  f_method;
  logic [3:0]  f_ramp;
  logic [3:0]  f_align;
  logic [3:0]  f_cap;
  logic [2:0]  f_pulse;
  logic [4:0]  f_thr;
  logic [1:0]  f_lead;
  logic [1:0]  f_repeat;
  logic [2:0]  runs;
  logic [17:0] sum_now;
  logic [33:0] third;

  always_comb begin
    f_method = q.cfg[METHOD_LSB +: 2];
    f_ramp   = q.cfg[RAMP_LSB +: 4];
    f_align  = q.cfg[ALIGN_LSB +: 4];
    f_cap    = q.cfg[CAP_LSB +: 4];
    f_pulse  = q.cfg[PULSE_LSB +: 3];
    f_thr    = q.cfg[THR_LSB +: 5];
    f_lead   = q.cfg[LEAD_LSB +: 2];
    f_repeat = q.cfg[REPEAT_LSB +: 2];
    runs     = {1'b0, f_repeat} + 3'h1;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_q             = q;
    next_start         = 1'b0;
    next_ticks         = ALIGN_TABLE[f_align];
    next_q.align_done  = 1'b0;
    next_q.probe_valid = 1'b0;
    sum_now            = q.probe_sum + {2'h0, probe_angle};
    third              = sum_now * RECIP_THREE;

    // register port
    if (reg_wr && reg_addr == ADDR_STARTUP_CFG) begin
      next_q.cfg = reg_wdata;
    end
    next_q.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STARTUP_CFG: next_q.rdata = q.cfg;
        ADDR_STATUS: begin
          next_q.rdata[ST_HOLD_BUSY]      = hold.busy;
          next_q.rdata[ST_DOUBLE_2ND]     = (q.hstate == HOLD_SECOND);
          next_q.rdata[ST_THR_BAD]        = q.thr_bad;
          next_q.rdata[ST_PROBE_CNT +: 3] = q.probe_cnt;
        end
        default: next_q.rdata = '0;
      endcase
    end

    // decoded settings, one cycle behind the word
    next_q.method      = startup_method_e'(f_method);
    next_q.ramp        = RAMP_TABLE[f_ramp];
    next_q.ramp_inf    = (f_ramp == RAMP_UNLIMITED);
    next_q.cap         = CAP_TABLE[f_cap];
    next_q.pulse       = PULSE_TABLE[f_pulse];
    next_q.thr_bad     = (f_thr >= THR_FIRST_BAD);
    next_q.thr         = (f_thr >= THR_FIRST_BAD) ? 16'h0000 : THR_TABLE[f_thr];
    next_q.release_tri = q.cfg[RELEASE_BIT];
    next_q.ol_cap      = q.cfg[CAPSRC_BIT] ? general_current_cap : openloop_current_cap;
    next_q.rampdown    = q.cfg[RAMPDN_BIT];
    next_q.brake       = q.cfg[BRAKE_BIT];
    next_q.rev_sel     = q.cfg[REVSEL_BIT];

    // alignment hold sequencing
    unique case (q.hstate)
      HOLD_IDLE: begin
        if (align_start && q.method != METHOD_POSITION) begin
          next_start    = 1'b1;
          next_q.hstate = HOLD_FIRST;
        end
      end
      HOLD_FIRST: begin
        if (hold.done) begin
          if (q.method == METHOD_DOUBLE_ALIGN) begin
            next_start    = 1'b1;
            next_q.hstate = HOLD_SECOND;
          end else begin
            next_q.hstate     = HOLD_IDLE;
            next_q.align_done = 1'b1;
          end
        end
      end
      HOLD_SECOND: begin
        if (hold.done) begin
          next_q.hstate     = HOLD_IDLE;
          next_q.align_done = 1'b1;
        end
      end
      default: next_q.hstate = HOLD_IDLE;
    endcase

    // position probe averaging
    if (probe_valid) begin
      if (q.probe_cnt + 3'h1 >= runs) begin
        next_q.probe_cnt   = '0;
        next_q.probe_sum   = '0;
        next_q.probe_valid = 1'b1;
        unique case (f_repeat)
          2'h0: next_q.probe_result = sum_now[15:0] + LEAD_TABLE[f_lead];
          2'h1: next_q.probe_result = sum_now[16:1] + LEAD_TABLE[f_lead];
          2'h2: next_q.probe_result = third[31:16] + LEAD_TABLE[f_lead];
          2'h3: next_q.probe_result = sum_now[17:2] + LEAD_TABLE[f_lead];
        endcase
      end else begin
        next_q.probe_cnt = q.probe_cnt + 3'h1;
        next_q.probe_sum = sum_now;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q     <= '0;
      q.cfg <= CFG_RESET;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata                    = q.rdata;
  assign startup_method_sel           = q.method;
  assign ramp_rate                    = q.ramp;
  assign ramp_unlimited               = q.ramp_inf;
  assign prestart_current_cap         = q.cap;
  assign align_active                 = (q.hstate != HOLD_IDLE);
  assign align_done                   = q.align_done;
  assign position_probe_pulse_rate    = q.pulse;
  assign position_probe_threshold     = q.thr;
  assign position_probe_threshold_bad = q.thr_bad;
  assign position_probe_release       = q.release_tri;
  assign position_probe_result        = q.probe_result;
  assign position_probe_result_valid  = q.probe_valid;
  assign openloop_cap                 = q.ol_cap;
  assign torque_current_rampdown_en   = q.rampdown;
  assign active_brake_en              = q.brake;
  assign reverse_param_set_sel        = q.rev_sel;

endmodule

// ===== rtl/startup_cfg_pkg.sv
// constants, field layout and code tables of the start-up configuration word
// assumes a 10 MHz system clock
package startup_cfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  ADDR_STARTUP_CFG = 8'h84;
  localparam logic [7:0]  ADDR_STATUS      = 8'h88;
  localparam logic [31:0] CFG_RESET        = 32'h0000_0000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int METHOD_LSB  = 29;
  localparam int RAMP_LSB    = 25;
  localparam int ALIGN_LSB   = 21;
  localparam int CAP_LSB     = 17;
  localparam int PULSE_LSB   = 14;
  localparam int THR_LSB     = 9;
  localparam int RELEASE_BIT = 8;
  localparam int LEAD_LSB    = 6;
  localparam int REPEAT_LSB  = 4;
  localparam int CAPSRC_BIT  = 3;
  localparam int RAMPDN_BIT  = 2;
  localparam int BRAKE_BIT   = 1;
  localparam int REVSEL_BIT  = 0;

  // status bits
  localparam int ST_HOLD_BUSY  = 0;
  localparam int ST_DOUBLE_2ND = 1;
  localparam int ST_THR_BAD    = 2;
  localparam int ST_PROBE_CNT  = 4;

  typedef enum logic [1:0] {
    METHOD_ALIGN        = 2'h0,
    METHOD_DOUBLE_ALIGN = 2'h1,
    METHOD_POSITION     = 2'h2,
    METHOD_SLOW_CYCLE   = 2'h3
  } startup_method_e;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ           = 10_000_000;
  localparam int HOLD_TICK_MS     = 10;
  localparam int HOLD_TICK_CYCLES = CLK_HZ / 1000 * HOLD_TICK_MS;

  // ****************************************
  // code tables
  // ****************************************
  // ramp rate in 0.1 A/s, code f unlimited
  localparam logic [15:0] RAMP_TABLE [16] = '{
    16'h0001, 16'h000a, 16'h0032, 16'h0064, 16'h0096, 16'h00fa, 16'h01f4, 16'h03e8,
    16'h05dc, 16'h07d0, 16'h09c4, 16'h1388, 16'h2710, 16'h4e20, 16'hc350, 16'h0000};
  localparam logic [3:0] RAMP_UNLIMITED = 4'hf;
  // alignment hold in 10 ms ticks
  localparam logic [10:0] ALIGN_TABLE [16] = '{
    11'h001, 11'h005, 11'h00a, 11'h014, 11'h01e, 11'h028, 11'h032, 11'h04b,
    11'h064, 11'h096, 11'h0c8, 11'h12c, 11'h190, 11'h1f4, 11'h2ee, 11'h3e8};
  // current cap in mA
  localparam logic [15:0] CAP_TABLE [16] = '{
    16'h007d, 16'h00fa, 16'h01f4, 16'h03e8, 16'h05dc, 16'h07d0, 16'h09c4, 16'h0bb8,
    16'h0dac, 16'h0fa0, 16'h1194, 16'h1388, 16'h157c, 16'h1770, 16'h1b58, 16'h1f40};
  // probe pulse rate in Hz
  localparam logic [15:0] PULSE_TABLE [8] = '{
    16'h0032, 16'h0064, 16'h00fa, 16'h01f4, 16'h03e8, 16'h07d0, 16'h1388, 16'h2710};
  // probe threshold in mA, codes from 12h unsupported
  localparam logic [15:0] THR_TABLE [18] = '{
    16'h00fa, 16'h01f4, 16'h02ee, 16'h03e8, 16'h04e2, 16'h05dc, 16'h07d0, 16'h09c4,
    16'h0bb8, 16'h0e53, 16'h0fa0, 16'h123b, 16'h1388, 16'h14d5, 16'h1770, 16'h1a0b,
    16'h1ca5, 16'h1f40};
  localparam logic [4:0] THR_FIRST_BAD = 5'h12;
  // lead angle, 16'h10000 = one electrical turn
  localparam logic [15:0] LEAD_TABLE [4] = '{16'h0000, 16'h1555, 16'h2aab, 16'h4000};
  // reciprocal of three in q16
  localparam logic [15:0] RECIP_THREE = 16'h5556;

endpackage

// ===== test/motor_startup_monitor.sv
// checker for the start-up configuration decoder
// assumes it is bound into motor_startup_config_decode
`timescale 1ns/100ps
module motor_startup_monitor
  import startup_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = HOLD_TICK_CYCLES
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        align_start,
  input startup_method_e  startup_method_sel,
  input wire logic        ramp_unlimited,
  input wire logic        align_active,
  input wire logic        align_done,
  input wire logic        position_probe_threshold_bad,
  input wire logic        torque_current_rampdown_en,
  input wire logic        active_brake_en,
  input wire logic        reverse_param_set_sel
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  int held;
  // cycles spent in the hold so far
  always_ff @(posedge clk_sys) begin
    if (reset || !align_active) held <= 0;
    else if (clk_en) held <= held + 1;
  end
  sequence cfg_wr;
    clk_en && reg_wr && reg_addr == ADDR_STARTUP_CFG;
  endsequence
  sequence settled;
    cfg_wr ##1 clk_en ##1 clk_en;
  endsequence
  method_dec_a: assert property (settled |-> startup_method_sel == $past(reg_wdata[30:29], 2))
    else $error("method decode wrong");
  ramp_unlim_a: assert property (settled |-> ramp_unlimited == (&$past(reg_wdata[28:25], 2)))
    else $error("unlimited ramp flag wrong");
  thr_bad_a: assert property (settled |-> position_probe_threshold_bad == ($past(reg_wdata[13:9], 2) >= 5'h12))
    else $error("threshold flag wrong");
  rampdown_a: assert property (settled |-> torque_current_rampdown_en == $past(reg_wdata[2], 2))
    else $error("rampdown enable wrong");
  brake_en_a: assert property (settled |-> active_brake_en == $past(reg_wdata[1], 2))
    else $error("brake enable wrong");
  rev_sel_a: assert property (settled |-> reverse_param_set_sel == $past(reg_wdata[0], 2))
    else $error("reverse select wrong");
  idle_rdata_a: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property (clk_en && reg_rd && reg_addr != ADDR_STARTUP_CFG && reg_addr != ADDR_STATUS
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  hold_go_a: assert property (clk_en && align_start && !align_active
    && startup_method_sel != METHOD_POSITION |=> align_active)
    else $error("hold did not start");
  probe_refuse_a: assert property (clk_en && align_start && !align_active
    && startup_method_sel == METHOD_POSITION |=> !align_active)
    else $error("hold started in probe method");
  hold_end_a: assert property (align_done && $past(clk_en) |-> !align_active && $past(align_active))
    else $error("hold end malformed");
  hold_min_a: assert property (align_done |-> held >= TICK_CYCLES)
    else $error("hold too short");
endmodule

bind motor_startup_config_decode motor_startup_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .clk_sys, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .align_start,
  .startup_method_sel, .ramp_unlimited, .align_active, .align_done, .position_probe_threshold_bad,
  .torque_current_rampdown_en, .active_brake_en, .reverse_param_set_sel
);

// ===== test/testbench.sv
// self-checking bench for the start-up configuration decoder
// assumes the hold timer runs with four cycles per tick
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  n_tests++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end
module testbench
  import startup_cfg_pkg::*;
;
  logic            clk_sys = 1'h0, reset = 1'h1, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic            align_start = 1'h0, probe_valid = 1'h0;
  logic [7:0]      reg_addr = 8'h0;
  logic [31:0]     reg_wdata = 32'h0, reg_rdata, w, d;
  logic [15:0]     probe_angle = 16'h0, general_current_cap = 16'h1234, openloop_current_cap = 16'h0567;
  startup_method_e startup_method_sel;
  logic [15:0]     ramp_rate, prestart_current_cap, position_probe_pulse_rate, position_probe_threshold;
  logic [15:0]     position_probe_result, openloop_cap;
  logic            ramp_unlimited, align_active, align_done, position_probe_threshold_bad;
  logic            position_probe_release, position_probe_result_valid, torque_current_rampdown_en;
  logic            active_brake_en, reverse_param_set_sel;
  int              failures = 0, n_tests = 0, k;

  motor_startup_config_decode #(.TICK_CYCLES(4)) i_dut (
    .clk_sys, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .align_start,
    .probe_angle, .probe_valid, .general_current_cap, .openloop_current_cap, .startup_method_sel,
    .ramp_rate, .ramp_unlimited, .prestart_current_cap, .align_active, .align_done,
    .position_probe_pulse_rate, .position_probe_threshold, .position_probe_threshold_bad,
    .position_probe_release, .position_probe_result, .position_probe_result_valid, .openloop_cap,
    .torque_current_rampdown_en, .active_brake_en, .reverse_param_set_sel
  );

  initial forever #50 clk_sys = ~clk_sys;

  // ****************************************
  // bus and wait tasks
  // ****************************************
  task automatic results;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    #1;
    for (k = 0; k < lim && s !== 1'h1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (k == lim) begin
      failures++;
      results();
    end
    // hand back on an edge so the next drive lands there
    @(posedge clk_sys);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(ADDR_STARTUP_CFG);
    `CHK("cfg word", CFG_RESET, d)
    `CHK("brake", 1'h0, active_brake_en)
    rd(8'h40);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_fields;
    logic [3:0] c;
    logic [4:0] t;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      t = {c[0], c};
      w = {c[2], c[1:0], c, c, c, c[2:0], t, c[0], c[1:0], c[1:0], c};
      wr(ADDR_STARTUP_CFG, w);
      rd(ADDR_STARTUP_CFG);
      `CHK("cfg word", w, d)
      `CHK("method", w[30:29], startup_method_sel)
      `CHK("ramp", RAMP_TABLE[c], ramp_rate)
      `CHK("unlimited", c == RAMP_UNLIMITED, ramp_unlimited)
      `CHK("prestart cap", CAP_TABLE[c], prestart_current_cap)
      `CHK("pulse", PULSE_TABLE[c[2:0]], position_probe_pulse_rate)
      `CHK("thr", (t < THR_FIRST_BAD) ? THR_TABLE[t] : 16'h0, position_probe_threshold)
      `CHK("thr bad", t >= THR_FIRST_BAD, position_probe_threshold_bad)
      `CHK("release", c[0], position_probe_release)
      `CHK("ol cap", c[3] ? general_current_cap : openloop_current_cap, openloop_cap)
      `CHK("rampdown", c[2], torque_current_rampdown_en)
      `CHK("brake", c[1], active_brake_en)
      `CHK("rev sel", c[0], reverse_param_set_sel)
    end
    clk_en <= 1'h0;
    wr(ADDR_STARTUP_CFG, 32'h0);
    clk_en <= 1'h1;
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STARTUP_CFG);
    `CHK("kept word", w, d)
    rd(ADDR_STATUS);
    `CHK("status", 32'h1 << ST_THR_BAD, d)
  endtask
  // lo of zero means the start must be refused
  task automatic t_hold(input logic [31:0] v, input int lo);
    wr(ADDR_STARTUP_CFG, v);
    @(posedge clk_sys);
    align_start <= 1'h1;
    @(posedge clk_sys);
    align_start <= 1'h0;
    if (lo == 0) begin
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("no hold", 1'h0, align_active)
      @(posedge clk_sys);
    end else begin
      wait_hi(align_done, 200);
      `CHK("hold time", 1'h1, k >= lo && k <= lo + 6)
    end
  endtask
  task automatic t_probe;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_STARTUP_CFG, {24'h0, 2'(r), 2'(r), 4'h0});
      for (int j = 0; j <= r; j++) begin
        probe_angle <= 16'(16'h1000 * (j + 1));
        probe_valid <= 1'h1;
        @(posedge clk_sys);
      end
      probe_valid <= 1'h0;
      wait_hi(position_probe_result_valid, 4);
      `CHK("probe", 16'(16'h0800 * (r + 2)) + LEAD_TABLE[r], position_probe_result)
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    t_reset();
    t_fields();
    t_hold(32'h0000_0000, 3);
    t_hold(32'h2020_0000, 39);
    t_hold(32'h4000_0000, 0);
    t_probe();
    results();
  end
endmodule
